// File: src/rmtd_top.sv
// Register map table source and register address decoder
`timescale 1ns/10ps
`include "rmtd_map.svh"

// How it works
// RL1 - Physical register address equals block base plus eight-bit local address.
// RL2 - Separate volatile and non-volatile 32-bit bases; decoder reports which block.
// RL3 - Byte-0 placement: local address forms the low byte.
// RL4 - Byte-1 placement: local address sits in byte 1, byte 0 from base.
// RL5 - Host drops upper bits when the device uses fewer address bits.
// RL6 - Host sends only the address width the device expects.
// RL7 - Host reads, merges and writes back whole physical registers.
// RL8 - Host may use atomic read-modify-write when offered.
// RL9 - Header word 0 bits 31:24 hold table length in DWORDs, one based.
// RL10 - Header word 0 bits 23:16 hold major revision 1.
// RL11 - Header word 0 bits 15:8 hold minor revision 0.
// RL12 - Header word 0 bits 7:0 hold identifier low byte.
// RL13 - Header word 1 bits 31:24 hold identifier high byte.
// RL14 - Header word 1 bits 23:0 hold DWORD-aligned table start pointer.
// RL15 - Table word 0 holds the volatile block base offset.
// RL16 - Table word 1 holds the non-volatile block base offset.
// RL17 - Table word 2 bits 29:28 give command length; 00 means six bytes.
// RL18 - Table word 2 bits 27:23 give volatile read dummy cycles, 0 to 31.
// RL19 - Host treats a bad identifier or pointer as no table.
module rmtd_top
  import rmtd_pkg::*;
(
  // Clock and reset
  input  wire logic                     CLK,
  input  wire logic                     RST_N,
  // Parameter space read
  input  wire logic                     RD_REQ,
  input  wire logic [23:0]              RD_ADDR,
  output rmtd_pkg::rmtd_rd_resp_t       RD_RESP,
  output logic                          RD_VALID,
  // Register address decode
  input  wire logic                     REG_REQ,
  input  wire logic [31:0]              REG_ADDR,
  output rmtd_pkg::rmtd_reg_resp_t      REG_RESP,
  output logic                          REG_VALID
);
  import rmtd_pkg::*;

  wire logic [31:0]    hdr0_word;
  wire logic [31:0]    hdr1_word;
  wire logic [31:0]    tbl2_word;
  wire logic           sel_hdr0;
  wire logic           sel_hdr1;
  wire logic           sel_tbl0;
  wire logic           sel_tbl1;
  wire logic           sel_tbl2;
  wire logic [31:0]    diff_vol;
  wire logic [31:0]    diff_nv;
  wire logic           hit_vol;
  wire logic           hit_nv;
  rmtd_rd_resp_t       rd_resp_nxt;
  rmtd_reg_resp_t      reg_resp_nxt;
  rmtd_rd_resp_t       rd_resp_r;
  rmtd_reg_resp_t      reg_resp_r;
  logic                rd_valid_r;
  logic                reg_valid_r;

  // Header and descriptor words
  assign hdr0_word = {`RMTD_TABLE_LEN, `RMTD_REV_MAJOR,
                      `RMTD_REV_MINOR, `RMTD_ID_LSB};    // RL9 RL10 RL11 RL12
  assign hdr1_word = {`RMTD_ID_MSB, `RMTD_PTR_ADDR};     // RL13 RL14
  assign tbl2_word = {`RMTD_RD_SUPPORT, `RMTD_WR_SUPPORT,
                      `RMTD_CMDLEN_6B, `RMTD_DUMMY_VOL,
                      `RMTD_DUMMY_NV, 18'h0_0000};       // RL17 RL18

  // Exact match rejects byte offsets inside a word
  assign sel_hdr0 = RD_ADDR == `RMTD_HDR_ADDR;
  assign sel_hdr1 = RD_ADDR == `RMTD_HDR_ADDR + `RMTD_DW_STEP;
  assign sel_tbl0 = RD_ADDR == `RMTD_PTR_ADDR;
  assign sel_tbl1 = RD_ADDR == `RMTD_PTR_ADDR + `RMTD_DW_STEP;
  assign sel_tbl2 = RD_ADDR == `RMTD_PTR_ADDR + 24'h00_0008;

  assign rd_resp_nxt.hit  = sel_hdr0 | sel_hdr1 | sel_tbl0 |
                            sel_tbl1 | sel_tbl2;
  assign rd_resp_nxt.data = sel_hdr0 ? hdr0_word :
                            sel_hdr1 ? hdr1_word :
                            sel_tbl0 ? `RMTD_VOL_BASE :  // RL15
                            sel_tbl1 ? `RMTD_NV_BASE :   // RL16
                            sel_tbl2 ? tbl2_word :
                            32'h0000_0000;

  // Subtract the base so a sum with carry still decodes
  assign diff_vol = REG_ADDR - `RMTD_VOL_BASE;           // RL1
  assign diff_nv  = REG_ADDR - `RMTD_NV_BASE;            // RL1
  assign hit_vol  = `RMTD_LOCAL_BYTE1 ?
                    (diff_vol[31:16] == 16'h0000 &&
                     diff_vol[7:0] == 8'h00) :           // RL4
                    (diff_vol[31:8] == 24'h00_0000);     // RL3
  assign hit_nv   = `RMTD_LOCAL_BYTE1 ?
                    (diff_nv[31:16] == 16'h0000 &&
                     diff_nv[7:0] == 8'h00) :            // RL4
                    (diff_nv[31:8] == 24'h00_0000);      // RL3

  // Volatile wins if the two blocks overlap
  assign reg_resp_nxt.vol        = hit_vol;              // RL2
  assign reg_resp_nxt.nonvol     = hit_nv & ~hit_vol;    // RL2
  assign reg_resp_nxt.local_addr =
    ~(hit_vol | hit_nv)  ? 8'h00 :
    `RMTD_LOCAL_BYTE1    ? (hit_vol ? diff_vol[15:8] : diff_nv[15:8]) :
                           (hit_vol ? diff_vol[7:0]  : diff_nv[7:0]);

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rd_resp_r   <= '0;
      rd_valid_r  <= 1'b0;
      reg_resp_r  <= '0;
      reg_valid_r <= 1'b0;
    end
    else
    begin
      rd_valid_r  <= RD_REQ;
      rd_resp_r   <= RD_REQ ? rd_resp_nxt : '0;
      reg_valid_r <= REG_REQ;
      reg_resp_r  <= REG_REQ ? reg_resp_nxt : '0;
    end
  end

  assign RD_RESP   = rd_resp_r;
  assign RD_VALID  = rd_valid_r;
  assign REG_RESP  = reg_resp_r;
  assign REG_VALID = reg_valid_r;

  a_hdr0_len: assert property (@(posedge CLK) disable iff (!RST_N) // RL9
    RD_REQ && RD_ADDR == `RMTD_HDR_ADDR |=>
    RD_VALID && RD_RESP.hit && RD_RESP.data[31:24] == 8'h03)
    else $error("table length field wrong");

  a_hdr0_major: assert property (@(posedge CLK) disable iff (!RST_N) // RL10
    RD_REQ && RD_ADDR == `RMTD_HDR_ADDR |=> RD_RESP.data[23:16] == 8'h01)
    else $error("major revision not one");

  a_hdr0_minor: assert property (@(posedge CLK) disable iff (!RST_N) // RL11
    RD_REQ && RD_ADDR == `RMTD_HDR_ADDR |=> RD_RESP.data[15:8] == 8'h00)
    else $error("minor revision not zero");

  a_hdr_ident: assert property (@(posedge CLK) disable iff (!RST_N) // RL12
    RD_REQ && RD_ADDR == `RMTD_HDR_ADDR ##1 RD_REQ &&
    RD_ADDR == `RMTD_HDR_ADDR + 24'h00_0004 |=>
    {RD_RESP.data[31:24], $past(RD_RESP.data[7:0])} ==
    {`RMTD_ID_MSB, `RMTD_ID_LSB})
    else $error("identifier bytes wrong");

  a_hdr1_ptr: assert property (@(posedge CLK) disable iff (!RST_N) // RL14
    RD_REQ && RD_ADDR == `RMTD_HDR_ADDR + 24'h00_0004 |=>
    RD_RESP.data[1:0] == 2'h0 && RD_RESP.data[23:0] == `RMTD_PTR_ADDR)
    else $error("table pointer wrong or misaligned");

  a_vol_base: assert property (@(posedge CLK) disable iff (!RST_N) // RL15
    RD_REQ && RD_ADDR == hdr1_word[23:0] |=>
    RD_RESP.data == `RMTD_VOL_BASE)
    else $error("volatile base wrong");

  a_nv_base: assert property (@(posedge CLK) disable iff (!RST_N) // RL16
    RD_REQ && RD_ADDR == hdr1_word[23:0] + 24'h00_0004 |=>
    RD_RESP.data == `RMTD_NV_BASE)
    else $error("non-volatile base wrong");

  a_cmd_dummy: assert property (@(posedge CLK) disable iff (!RST_N) // RL17
    RD_REQ && RD_ADDR == hdr1_word[23:0] + 24'h00_0008 |=>
    RD_RESP.data[29:28] == 2'h0 &&
    RD_RESP.data[27:23] == `RMTD_DUMMY_VOL)               // RL18
    else $error("command descriptor wrong");

  a_rd_answer: assert property (@(posedge CLK) disable iff (!RST_N) // read answer one cycle after each request
    RD_REQ |=> RD_VALID ##1 (RD_VALID == $past(RD_REQ)))
    else $error("read answer latency wrong");

  a_reg_sum: assert property (@(posedge CLK) disable iff (!RST_N) // RL1
    REG_VALID && (REG_RESP.vol || REG_RESP.nonvol) |->
    (REG_RESP.vol ? `RMTD_VOL_BASE : `RMTD_NV_BASE) +
    (`RMTD_LOCAL_BYTE1 ? {16'h0000, REG_RESP.local_addr, 8'h00} :
                         {24'h00_0000, REG_RESP.local_addr}) ==
    $past(REG_ADDR))
    else $error("base plus local does not rebuild address");

  a_reg_block: assert property (@(posedge CLK) disable iff (!RST_N) // RL2
    REG_REQ && REG_ADDR == `RMTD_VOL_BASE |=>
    REG_VALID && REG_RESP.vol && !REG_RESP.nonvol &&
    REG_RESP.local_addr == 8'h00)
    else $error("volatile block not selected");

  a_hdr0_idlow: assert property (@(posedge CLK) disable iff (!RST_N) // RL12
    RD_REQ && RD_ADDR == `RMTD_HDR_ADDR |=>
    RD_RESP.data[7:0] == `RMTD_ID_LSB)
    else $error("identifier low byte wrong");

  a_hdr1_idhigh: assert property (@(posedge CLK) disable iff (!RST_N) // RL13
    RD_REQ && RD_ADDR == `RMTD_HDR_ADDR + `RMTD_DW_STEP |=>
    RD_VALID && RD_RESP.hit && RD_RESP.data[31:24] == `RMTD_ID_MSB)
    else $error("identifier high byte wrong");

  a_rd_unaligned: assert property (@(posedge CLK) disable iff (!RST_N) // RL14
    RD_REQ && RD_ADDR[1:0] != 2'h0 |=>
    RD_VALID && !RD_RESP.hit && RD_RESP.data == 32'h0000_0000)
    else $error("unaligned read answered");

  a_rd_past_end: assert property (@(posedge CLK) disable iff (!RST_N) // RL9
    RD_REQ && RD_ADDR == `RMTD_PTR_ADDR + 24'h00_000C |=>
    RD_VALID && !RD_RESP.hit && RD_RESP.data == 32'h0000_0000)
    else $error("read past table end answered");

  a_reg_onehot: assert property (@(posedge CLK) disable iff (!RST_N) // RL2
    REG_VALID |-> !(REG_RESP.vol && REG_RESP.nonvol))
    else $error("both register blocks selected");

  a_reg_low_byte: assert property (@(posedge CLK) disable iff (!RST_N) // RL3
    REG_REQ && !`RMTD_LOCAL_BYTE1 &&
    REG_ADDR - `RMTD_VOL_BASE < 32'h0000_0100 |=>
    REG_VALID && REG_RESP.vol && REG_RESP.local_addr == $past(REG_ADDR[7:0]))
    else $error("low byte local address wrong");

  a_reg_miss: assert property (@(posedge CLK) disable iff (!RST_N) // RL2
    REG_REQ && REG_ADDR == `RMTD_VOL_BASE + 32'h0000_0100 |=>
    REG_VALID && !REG_RESP.vol && !REG_RESP.nonvol &&
    REG_RESP.local_addr == 8'h00)
    else $error("address outside both blocks decoded");

  a_reg_nv_sel: assert property (@(posedge CLK) disable iff (!RST_N) // RL2
    REG_REQ && REG_ADDR == `RMTD_NV_BASE + 32'h0000_007C |=>
    REG_VALID && REG_RESP.nonvol && REG_RESP.local_addr == 8'h7C)
    else $error("non-volatile block not selected");
endmodule

// File: src/rmtd_map.svh
// Offsets, field positions, table contents and timing counts for the map table
`ifndef RMTD_MAP_SVH
`define RMTD_MAP_SVH

// Byte addresses in the parameter space
`define RMTD_HDR_ADDR      24'h00_0010
`define RMTD_PTR_ADDR      24'h00_0100
`define RMTD_DW_STEP       24'h00_0004

// Header word 0 fields
`define RMTD_LEN_MSB       31
`define RMTD_LEN_LSB       24
`define RMTD_MAJ_MSB       23
`define RMTD_MAJ_LSB       16
`define RMTD_MIN_MSB       15
`define RMTD_MIN_LSB       8
`define RMTD_IDL_MSB       7
`define RMTD_IDL_LSB       0
`define RMTD_TABLE_LEN     8'h03
`define RMTD_REV_MAJOR     8'h01
`define RMTD_REV_MINOR     8'h00
// Identifier bytes: arbitrary values
`define RMTD_ID_LSB        8'hA5
`define RMTD_ID_MSB        8'h5A

// Header word 1 fields
`define RMTD_IDM_MSB       31
`define RMTD_IDM_LSB       24
`define RMTD_PTR_MSB       23
`define RMTD_PTR_LSB       0

// Register block bases
`define RMTD_VOL_BASE      32'h0080_0000
`define RMTD_NV_BASE       32'h0000_0000

// Third table word fields
`define RMTD_RDSUP_BIT     31
`define RMTD_WRSUP_BIT     30
`define RMTD_CMDLEN_MSB    29
`define RMTD_CMDLEN_LSB    28
`define RMTD_DMYV_MSB      27
`define RMTD_DMYV_LSB      23
`define RMTD_DMYN_MSB      22
`define RMTD_DMYN_LSB      18
`define RMTD_RD_SUPPORT    1'b1
`define RMTD_WR_SUPPORT    1'b1
`define RMTD_CMDLEN_6B     2'h0
`define RMTD_DUMMY_VOL     5'h08
`define RMTD_DUMMY_NV      5'h10

// Local address placement: 0 puts it in byte 0, 1 in byte 1
`define RMTD_LOCAL_BYTE1   1'b0

// Answer latency in cycles
`define RMTD_RD_LAT        1
`endif

// File: src/rmtd_pkg.sv
// Types shared by the map table block
package rmtd_pkg;
  typedef struct packed {
    logic        hit;
    logic [31:0] data;
  } rmtd_rd_resp_t;

  typedef struct packed {
    logic       vol;
    logic       nonvol;
    logic [7:0] local_addr;
  } rmtd_reg_resp_t;
endpackage

// File: tb/rmtd_host.sv
// Host controller model that walks the map table and forms addresses
`timescale 1ns/10ps
`include "rmtd_map.svh"
module rmtd_host
  import rmtd_pkg::*;
(
  // Clock
  input  wire logic               clk,
  // Parameter space read
  output logic                    rd_req,
  output logic [23:0]             rd_addr,
  input  rmtd_pkg::rmtd_rd_resp_t rd_resp,
  input  wire logic               rd_valid,
  // Register decode
  output logic                    reg_req,
  output logic [31:0]             reg_addr,
  input  rmtd_pkg::rmtd_reg_resp_t reg_resp,
  input  wire logic               reg_valid
);
  logic [31:0] vol_base;
  logic [31:0] nv_base;
  logic        table_ok;
  logic        rd_seen;
  logic        reg_seen;
  initial
  begin
    rd_req   = 1'b0;
    rd_addr  = 24'h00_0000;
    reg_req  = 1'b0;
    reg_addr = 32'h0000_0000;
  end
  // Held across one rising edge; the answer is taken a half cycle later
  task automatic rd(input logic [23:0] a, output rmtd_rd_resp_t r);
    @(negedge clk);
    rd_req  = 1'b1;
    rd_addr = a;
    @(negedge clk);
    rd_req  = 1'b0;
    rd_addr = ~a;
    r = rd_resp;
    rd_seen = rd_valid;
  endtask
  // Back-to-back pair: each answer is taken while it stands
  task automatic rd2(input logic [23:0] a0, input logic [23:0] a1,
                     output rmtd_rd_resp_t r0, output rmtd_rd_resp_t r1);
    @(negedge clk);
    rd_req  = 1'b1;
    rd_addr = a0;
    @(negedge clk);
    rd_addr = a1;
    r0      = rd_resp;
    rd_seen = rd_valid;
    @(negedge clk);
    rd_req  = 1'b0;
    rd_addr = ~a1;
    r1      = rd_resp;
    rd_seen = rd_seen & rd_valid;
  endtask
  task automatic dec(input logic [31:0] a, output rmtd_reg_resp_t r);
    @(negedge clk);
    reg_req  = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_req  = 1'b0;
    reg_addr = ~a;
    r = reg_resp;
    reg_seen = reg_valid;
  endtask
  // A table with a foreign identifier or odd pointer is ignored
  task automatic discover();
    rmtd_rd_resp_t w0;
    rmtd_rd_resp_t w1;
    rmtd_rd_resp_t r;
    rd(`RMTD_HDR_ADDR, w0);
    rd(`RMTD_HDR_ADDR + `RMTD_DW_STEP, w1);
    table_ok = ({w1.data[31:24], w0.data[7:0]}
                === {`RMTD_ID_MSB, `RMTD_ID_LSB})
               && (w1.data[1:0] === 2'b00);
    if (table_ok)
    begin
      rd(w1.data[23:0], r);
      vol_base = r.data;
      rd(w1.data[23:0] + `RMTD_DW_STEP, r);
      nv_base = r.data;
    end
  endtask
  // Byte-0 placement only; upper bits come from the base
  function automatic logic [31:0] phys(input logic v, input logic [7:0] l);
    phys = (v ? vol_base : nv_base) + {24'h00_0000, l};
  endfunction
  // No atomic update is offered, so the host merges by hand
  function automatic logic [31:0] merge(input logic [31:0] cur,
                                        input logic [31:0] mask,
                                        input logic [31:0] val);
    merge = (cur & ~mask) | (val & mask);
  endfunction
  // Keeps only the low address bits that a narrow device decodes
  function automatic logic [31:0] narrow(input logic [31:0] a,
                                         input logic [5:0]  bits);
    narrow = (bits >= 6'h20) ? a :
             a & ((32'h0000_0001 << bits) - 32'h0000_0001);
  endfunction
endmodule

// File: tb/testbench.sv
// Self-checking bench for the map table block
`timescale 1ns/10ps
`include "rmtd_map.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  err_total++; $display("Error %s exp %h got %h", n, e, g); end end
module testbench;
  import rmtd_pkg::*;
  logic           CLK;
  logic           RST_N;
  logic           rd_req;
  logic           reg_req;
  logic           rd_valid;
  logic           reg_valid;
  logic [23:0]    rd_addr;
  logic [31:0]    reg_addr;
  rmtd_rd_resp_t  rd_resp;
  rmtd_reg_resp_t reg_resp;
  rmtd_rd_resp_t  r;
  rmtd_rd_resp_t  q;
  rmtd_reg_resp_t d;
  int             err_total;
  int             num_checks;
  rmtd_top rmtd_top_inst (.CLK(CLK), .RST_N(RST_N), .RD_REQ(rd_req),
    .RD_ADDR(rd_addr), .RD_RESP(rd_resp), .RD_VALID(rd_valid),
    .REG_REQ(reg_req), .REG_ADDR(reg_addr), .REG_RESP(reg_resp),
    .REG_VALID(reg_valid));
  rmtd_host rmtd_host_inst (.clk(CLK), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_resp(rd_resp), .rd_valid(rd_valid), .reg_req(reg_req),
    .reg_addr(reg_addr), .reg_resp(reg_resp), .reg_valid(reg_valid));
  initial
  begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  task automatic results();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_header();
    rmtd_host_inst.rd2(`RMTD_HDR_ADDR, `RMTD_HDR_ADDR + 24'h00_0004, r, q);
    `CHK("rvalid", 1'b1, rmtd_host_inst.rd_seen)
    `CHK("hit0", 1'b1, r.hit)
    `CHK("len", 8'h03, r.data[31:24])
    `CHK("major", 8'h01, r.data[23:16])
    `CHK("minor", 8'h00, r.data[15:8])
    `CHK("idl", `RMTD_ID_LSB, r.data[7:0])
    `CHK("hit1", 1'b1, q.hit)
    `CHK("idm", `RMTD_ID_MSB, q.data[31:24])
    `CHK("ptr", `RMTD_PTR_ADDR, q.data[23:0])
    `CHK("align", 2'b00, q.data[1:0])
  endtask
  task automatic t_table();
    logic [31:0] w;
    rmtd_host_inst.discover();
    `CHK("ok", 1'b1, rmtd_host_inst.table_ok)
    `CHK("vol", 32'h0080_0000, rmtd_host_inst.vol_base)
    `CHK("nv", 32'h0000_0000, rmtd_host_inst.nv_base)
    rmtd_host_inst.rd(`RMTD_PTR_ADDR + 24'h00_0008, r);
    `CHK("cmdlen", 2'b00, r.data[29:28])
    `CHK("dmyv", 5'h08, r.data[27:23])
    w = rmtd_host_inst.merge(r.data, 32'h0F80_0000, 32'hFFFF_FFFF);
    `CHK("rmw", 32'hCFC0_0000, w)
    rmtd_host_inst.rd(`RMTD_PTR_ADDR + 24'h00_000C, r);
    `CHK("past end", 33'h0_0000_0000, r)
    rmtd_host_inst.rd(`RMTD_HDR_ADDR + 24'h00_0002, r);
    `CHK("unaligned", 33'h0_0000_0000, r)
  endtask
  task automatic t_decode();
    logic [31:0] a [6];
    logic [9:0]  e [6];
    logic [31:0] n;
    a = '{rmtd_host_inst.phys(1'b1, 8'h23), rmtd_host_inst.phys(1'b1, 8'hFF),
          rmtd_host_inst.phys(1'b0, 8'h00), rmtd_host_inst.phys(1'b0, 8'h7C),
          32'h0080_0100, 32'h0000_0100};
    e = '{10'h223, 10'h2FF, 10'h100, 10'h17C, 10'h000, 10'h000};
    foreach (a[i])
    begin
      rmtd_host_inst.dec(a[i], d);
      `CHK("decode", e[i], d)
      `CHK("dvalid", 1'b1, rmtd_host_inst.reg_seen)
    end
    n = rmtd_host_inst.narrow(a[0], 6'h08);
    `CHK("narrow8", 32'h0000_0023, n)
    n = rmtd_host_inst.narrow(a[0], 6'h18);
    `CHK("narrow24", 32'h0080_0023, n)
  endtask
  // Reset in mid-run clears a standing answer at once
  task automatic t_reset();
    rmtd_host_inst.rd(`RMTD_HDR_ADDR, r);
    `CHK("pre rst", 1'b1, rmtd_host_inst.rd_seen)
    RST_N = 1'b0;
    #1;
    `CHK("mid rst", 35'h0_0000_0000, {rd_valid, rd_resp, reg_valid})
    repeat (2) @(negedge CLK);
    RST_N = 1'b1;
    rmtd_host_inst.rd(`RMTD_HDR_ADDR, r);
    `CHK("post rst", {1'b1, 8'h03, 8'h01, 8'h00, `RMTD_ID_LSB}, r)
  endtask
  initial
  begin
    err_total  = 0;
    num_checks = 0;
    RST_N      = 1'b0;
    repeat (10) @(posedge CLK);
    @(negedge CLK);
    `CHK("rst valid", 2'b00, {rd_valid, reg_valid})
    RST_N = 1'b1;
    t_header();
    t_table();
    t_decode();
    t_reset();
    results();
  end
  // Whole run needs well under 200 cycles
  initial
  begin
    repeat (2000) @(posedge CLK);
    err_total++;
    results();
  end
endmodule
